// *** inc/io_expansion_config_defines.svh ***
// How it works
// - Input-type bit per channel, 1 means counter
// - Six-input word bits 0-5, others 0-3
// - Pulse constant 1 to 65535, resets 0
// - Relay work mode: 0 control, 1 alarm
// - Relay drive mode: 0 latch, 1 pulse
// - Relay pulse width 50-3000 ms, reset 50
// - Output source 0 none, 1-4 energy kinds
// - Loop type 0-3, strap picks reset 1/2
// - Four follow selectors, each resetting to 0
// - Follow selector codes run 0 to 29
// - Writes apply only to installed modules
`ifndef IO_EXPANSION_CONFIG_DEFINES_SVH
`define IO_EXPANSION_CONFIG_DEFINES_SVH

`define IOCFG_BASE 16'h10A3
`define IOCFG_COUNT 35
`define OFS_SWITCH_IN_TYPE_M21 16'h10A3
`define OFS_PULSE_CONST_M21 16'h10A4
`define OFS_OUT_MODE_M21 16'h10A5
`define OFS_OUT_PULSE_WIDTH_M21 16'h10A6
`define OFS_OUT1_SOURCE 16'h10A7
`define OFS_OUT2_SOURCE 16'h10A8
`define OFS_LOOP_OUT12_TYPE 16'h10A9
`define OFS_SWITCH_IN_TYPE_M31 16'h10AA
`define OFS_PULSE_CONST_M31 16'h10AB
`define OFS_RELAY34_WORK_MODE 16'h10AC
`define OFS_RELAY34_DRIVE_MODE 16'h10AD
`define OFS_RELAY34_PULSE_WIDTH 16'h10AE
`define OFS_LOOP_IN12_TYPE 16'h10AF
`define OFS_SWITCH_IN_TYPE_M12A 16'h10B0
`define OFS_PULSE_CONST_M12A 16'h10B1
`define OFS_RELAY56_WORK_MODE 16'h10B2
`define OFS_RELAY56_DRIVE_MODE 16'h10B3
`define OFS_RELAY56_PULSE_WIDTH 16'h10B4
`define OFS_SWITCH_IN_TYPE_M12B 16'h10B5
`define OFS_PULSE_CONST_M12B 16'h10B6
`define OFS_OUT34_MODE 16'h10B7
`define OFS_OUT34_PULSE_WIDTH 16'h10B8
`define OFS_OUT3_SOURCE 16'h10B9
`define OFS_OUT4_SOURCE 16'h10BA
`define OFS_LOOP_OUT34_TYPE 16'h10BB
`define OFS_SWITCH_IN_TYPE_M32 16'h10BC
`define OFS_PULSE_CONST_M32 16'h10BD
`define OFS_RELAY78_WORK_MODE 16'h10BE
`define OFS_RELAY78_DRIVE_MODE 16'h10BF
`define OFS_RELAY78_PULSE_WIDTH 16'h10C0
`define OFS_LOOP_IN34_TYPE 16'h10C1
`define OFS_LOOP_OUT1_FOLLOW_SEL 16'h10C2
`define OFS_LOOP_OUT2_FOLLOW_SEL 16'h10C3
`define OFS_LOOP_OUT3_FOLLOW_SEL 16'h10C4
`define OFS_LOOP_OUT4_FOLLOW_SEL 16'h10C5

// Reset values
`define RST_ZERO 16'h0000
`define RST_RELAY_WIDTH 16'h0032
`define RST_OUT_WIDTH 16'h0014
`define RST_LOOP_TYPE_CURRENT 16'h0001
`define RST_LOOP_TYPE_VOLTAGE 16'h0002

// Field widths and limits
`define TYPE4_MASK 16'h000F
`define TYPE6_MASK 16'h003F
`define PULSE_CONST_MIN 16'h0001
`define MODE_MAX 16'h0001
`define RELAY_WIDTH_MIN_MS 16'h0032
`define RELAY_WIDTH_MAX_MS 16'h0BB8
`define OUT_WIDTH_MIN_MS 16'h0014
`define OUT_WIDTH_MAX_MS 16'h03E8
`define SOURCE_MAX 16'h0004
`define LOOP_TYPE_MAX 16'h0003
`define FOLLOW_MAX 16'h001D

// Module slots
`define SLOT_M21 2'h0
`define SLOT_M31 2'h1
`define SLOT_M12 2'h2
`define SLOT_M32 2'h3

`endif

// *** inc/io_expansion_config_pkg.sv ***
`include "io_expansion_config_defines.svh"

package io_expansion_config_pkg;

    // What a register word holds, which decides its legal range
    typedef enum logic [3:0] {
        KIND_NONE,
        KIND_TYPE4,
        KIND_TYPE6,
        KIND_PULSE_CONST,
        KIND_MODE,
        KIND_RELAY_WIDTH,
        KIND_OUT_WIDTH,
        KIND_SOURCE,
        KIND_LOOP_TYPE,
        KIND_FOLLOW
    } word_kind_t;

    typedef struct packed {
        logic hit;
        word_kind_t kind;
        logic [1:0] slot;
        logic [5:0] index;
    } decode_t;

    // Start-up sequence while straps settle through the synchroniser
    typedef enum logic [1:0] {
        PH_WAIT1,
        PH_WAIT2,
        PH_LOAD,
        PH_RUN
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [`IOCFG_COUNT-1:0][15:0] words;
        logic [3:0] strapMeta;
        logic [3:0] strapSync;
        logic [3:0] installMeta;
        logic [3:0] installSync;
        logic [15:0] readData;
        logic readValid;
        logic readError;
        logic writeDone;
        logic writeRejected;
    } cfg_state_t;

endpackage : io_expansion_config_pkg

// *** design/io_expansion_config_regs.sv ***
`include "io_expansion_config_defines.svh"

module io_expansion_config_regs (
    input wire logic clock,
    input wire logic rst_n,
    // Word access from the serial-protocol engine
    input wire logic [15:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [15:0] regWriteData,
    output logic [15:0] regReadData,
    output logic regReadValid,
    output logic regReadError,
    output logic regWriteDone,
    output logic regWriteRejected,
    // Pins: module presence and loop variant straps
    input wire logic [3:0] moduleInstalled,
    input wire logic [3:0] loopVoltageStrap,
    // Configuration toward the expansion logic
    output logic [4:0][5:0] switchInputType,
    output logic [4:0][15:0] switchInputPulseConst,
    output logic [2:0] relayWorkMode,
    output logic [2:0] relayDriveMode,
    output logic [2:0][15:0] relayPulseWidth,
    output logic [1:0] switchedOutMode,
    output logic [1:0][15:0] switchedOutPulseWidth,
    output logic [3:0][2:0] switchedOutSource,
    output logic [1:0][1:0] loopOutputType,
    output logic [1:0][1:0] loopSenseInputType,
    output logic [3:0][4:0] loopOutputFollow,
    output logic [3:0] moduleInstalledSync
);
    import io_expansion_config_pkg::*;

    cfg_state_t state_reg;
    cfg_state_t state_next;

    // Word index from a register address
    function automatic logic [5:0] wordIndex(input logic [15:0] addr);
        logic [15:0] diff;
        diff = addr - `IOCFG_BASE;
        return diff[5:0];
    endfunction : wordIndex

    // Address decode: kind of word and the module that owns it
    function automatic decode_t decodeAddr(input logic [15:0] addr);
        decode_t d;
        d.hit = 1'b1;
        d.index = wordIndex(addr);
        d.kind = KIND_NONE;
        d.slot = `SLOT_M21;
        case (addr)
            `OFS_SWITCH_IN_TYPE_M21:
                d.kind = KIND_TYPE4;
            `OFS_PULSE_CONST_M21:
                d.kind = KIND_PULSE_CONST;
            `OFS_OUT_MODE_M21:
                d.kind = KIND_MODE;
            `OFS_OUT_PULSE_WIDTH_M21:
                d.kind = KIND_OUT_WIDTH;
            `OFS_OUT1_SOURCE, `OFS_OUT2_SOURCE:
                d.kind = KIND_SOURCE;
            `OFS_LOOP_OUT12_TYPE:
                d.kind = KIND_LOOP_TYPE;
            `OFS_LOOP_OUT1_FOLLOW_SEL, `OFS_LOOP_OUT2_FOLLOW_SEL:
                d.kind = KIND_FOLLOW;
            `OFS_SWITCH_IN_TYPE_M31:
            begin
                d.kind = KIND_TYPE4;
                d.slot = `SLOT_M31;
            end
            `OFS_PULSE_CONST_M31:
            begin
                d.kind = KIND_PULSE_CONST;
                d.slot = `SLOT_M31;
            end
            `OFS_RELAY34_WORK_MODE, `OFS_RELAY34_DRIVE_MODE:
            begin
                d.kind = KIND_MODE;
                d.slot = `SLOT_M31;
            end
            `OFS_RELAY34_PULSE_WIDTH:
            begin
                d.kind = KIND_RELAY_WIDTH;
                d.slot = `SLOT_M31;
            end
            `OFS_LOOP_IN12_TYPE:
            begin
                d.kind = KIND_LOOP_TYPE;
                d.slot = `SLOT_M31;
            end
            `OFS_SWITCH_IN_TYPE_M12A:
            begin
                d.kind = KIND_TYPE6;
                d.slot = `SLOT_M12;
            end
            `OFS_PULSE_CONST_M12A, `OFS_PULSE_CONST_M12B:
            begin
                d.kind = KIND_PULSE_CONST;
                d.slot = `SLOT_M12;
            end
            `OFS_RELAY56_WORK_MODE, `OFS_RELAY56_DRIVE_MODE, `OFS_OUT34_MODE:
            begin
                d.kind = KIND_MODE;
                d.slot = `SLOT_M12;
            end
            `OFS_RELAY56_PULSE_WIDTH:
            begin
                d.kind = KIND_RELAY_WIDTH;
                d.slot = `SLOT_M12;
            end
            `OFS_SWITCH_IN_TYPE_M12B:
            begin
                d.kind = KIND_TYPE4;
                d.slot = `SLOT_M12;
            end
            `OFS_OUT34_PULSE_WIDTH:
            begin
                d.kind = KIND_OUT_WIDTH;
                d.slot = `SLOT_M12;
            end
            `OFS_OUT3_SOURCE, `OFS_OUT4_SOURCE:
            begin
                d.kind = KIND_SOURCE;
                d.slot = `SLOT_M12;
            end
            `OFS_LOOP_OUT34_TYPE:
            begin
                d.kind = KIND_LOOP_TYPE;
                d.slot = `SLOT_M12;
            end
            `OFS_LOOP_OUT3_FOLLOW_SEL, `OFS_LOOP_OUT4_FOLLOW_SEL:
            begin
                d.kind = KIND_FOLLOW;
                d.slot = `SLOT_M12;
            end
            `OFS_SWITCH_IN_TYPE_M32:
            begin
                d.kind = KIND_TYPE4;
                d.slot = `SLOT_M32;
            end
            `OFS_PULSE_CONST_M32:
            begin
                d.kind = KIND_PULSE_CONST;
                d.slot = `SLOT_M32;
            end
            `OFS_RELAY78_WORK_MODE, `OFS_RELAY78_DRIVE_MODE:
            begin
                d.kind = KIND_MODE;
                d.slot = `SLOT_M32;
            end
            `OFS_RELAY78_PULSE_WIDTH:
            begin
                d.kind = KIND_RELAY_WIDTH;
                d.slot = `SLOT_M32;
            end
            `OFS_LOOP_IN34_TYPE:
            begin
                d.kind = KIND_LOOP_TYPE;
                d.slot = `SLOT_M32;
            end
            default:
                d.hit = 1'b0;
        endcase
        return d;
    endfunction : decodeAddr

    // Range check of a written value per word kind
    function automatic logic inRange(input word_kind_t kind, input logic [15:0] v);
        logic ok;
        ok = 1'b0;
        unique case (kind)
            KIND_TYPE4:
                ok = ((v & ~`TYPE4_MASK) == `RST_ZERO);
            KIND_TYPE6:
                ok = ((v & ~`TYPE6_MASK) == `RST_ZERO);
            KIND_PULSE_CONST:
                ok = (v >= `PULSE_CONST_MIN);
            KIND_MODE:
                ok = (v <= `MODE_MAX);
            KIND_RELAY_WIDTH:
                ok = (v >= `RELAY_WIDTH_MIN_MS) && (v <= `RELAY_WIDTH_MAX_MS);
            KIND_OUT_WIDTH:
                ok = (v >= `OUT_WIDTH_MIN_MS) && (v <= `OUT_WIDTH_MAX_MS);
            KIND_SOURCE:
                ok = (v <= `SOURCE_MAX);
            KIND_LOOP_TYPE:
                ok = (v <= `LOOP_TYPE_MAX);
            KIND_FOLLOW:
                ok = (v <= `FOLLOW_MAX);
            KIND_NONE:
                ok = 1'b0;
        endcase
        return ok;
    endfunction : inRange

    // Loop type reset value from a synchronised strap
    function automatic logic [15:0] loopReset(input logic strap);
        return strap ? `RST_LOOP_TYPE_VOLTAGE : `RST_LOOP_TYPE_CURRENT;
    endfunction : loopReset

    // Reset image of the whole bank
    function automatic logic [`IOCFG_COUNT-1:0][15:0] resetWords();
        logic [`IOCFG_COUNT-1:0][15:0] w;
        for (int i = 0; i < `IOCFG_COUNT; i++)
        begin
            w[i] = `RST_ZERO;
        end
        w[wordIndex(`OFS_OUT_PULSE_WIDTH_M21)] = `RST_OUT_WIDTH;
        w[wordIndex(`OFS_OUT34_PULSE_WIDTH)] = `RST_OUT_WIDTH;
        w[wordIndex(`OFS_RELAY34_PULSE_WIDTH)] = `RST_RELAY_WIDTH;
        w[wordIndex(`OFS_RELAY56_PULSE_WIDTH)] = `RST_RELAY_WIDTH;
        w[wordIndex(`OFS_RELAY78_PULSE_WIDTH)] = `RST_RELAY_WIDTH;
        w[wordIndex(`OFS_LOOP_OUT12_TYPE)] = `RST_LOOP_TYPE_CURRENT;
        w[wordIndex(`OFS_LOOP_IN12_TYPE)] = `RST_LOOP_TYPE_CURRENT;
        w[wordIndex(`OFS_LOOP_OUT34_TYPE)] = `RST_LOOP_TYPE_CURRENT;
        w[wordIndex(`OFS_LOOP_IN34_TYPE)] = `RST_LOOP_TYPE_CURRENT;
        return w;
    endfunction : resetWords

    // Next-state logic: synchronisers, start-up, read and write
    always_comb
    begin
        decode_t dec;
        dec = decodeAddr(regAddr);
        state_next = state_reg;
        state_next.strapMeta = loopVoltageStrap;
        state_next.strapSync = state_reg.strapMeta;
        state_next.installMeta = moduleInstalled;
        state_next.installSync = state_reg.installMeta;
        state_next.readValid = 1'b0;
        state_next.readError = 1'b0;
        state_next.writeDone = 1'b0;
        state_next.writeRejected = 1'b0;
        unique case (state_reg.phase)
            PH_WAIT1:
                state_next.phase = PH_WAIT2;
            PH_WAIT2:
                state_next.phase = PH_LOAD;
            PH_LOAD:
            begin
                // Loop type words take their variant from the straps
                state_next.words[wordIndex(`OFS_LOOP_OUT12_TYPE)] =
                    loopReset(state_reg.strapSync[0]);
                state_next.words[wordIndex(`OFS_LOOP_IN12_TYPE)] =
                    loopReset(state_reg.strapSync[1]);
                state_next.words[wordIndex(`OFS_LOOP_OUT34_TYPE)] =
                    loopReset(state_reg.strapSync[2]);
                state_next.words[wordIndex(`OFS_LOOP_IN34_TYPE)] =
                    loopReset(state_reg.strapSync[3]);
                state_next.phase = PH_RUN;
            end
            PH_RUN:
                state_next.phase = PH_RUN;
        endcase
        // Holding-register read; unmapped addresses report an error
        if (regRead)
        begin
            state_next.readValid = dec.hit;
            state_next.readError = !dec.hit;
            state_next.readData = dec.hit ? state_reg.words[dec.index] : `RST_ZERO;
        end
        // Write lands only when installed, mapped, in range and running
        if (regWrite && !regRead)
        begin
            if (dec.hit && state_reg.phase == PH_RUN
                && state_reg.installSync[dec.slot]
                && inRange(dec.kind, regWriteData))
            begin
                state_next.words[dec.index] = regWriteData;
                state_next.writeDone = 1'b1;
            end
            else
            begin
                state_next.writeRejected = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '{
                phase: PH_WAIT1,
                words: resetWords(),
                strapMeta: 4'h0,
                strapSync: 4'h0,
                installMeta: 4'h0,
                installSync: 4'h0,
                readData: `RST_ZERO,
                readValid: 1'b0,
                readError: 1'b0,
                writeDone: 1'b0,
                writeRejected: 1'b0
            };
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Host-side answers
    assign regReadData = state_reg.readData;
    assign regReadValid = state_reg.readValid;
    assign regReadError = state_reg.readError;
    assign regWriteDone = state_reg.writeDone;
    assign regWriteRejected = state_reg.writeRejected;
    assign moduleInstalledSync = state_reg.installSync;

    // Switch-input type bits, one per channel from bit 0
    assign switchInputType[0] = {2'h0, state_reg.words[wordIndex(`OFS_SWITCH_IN_TYPE_M21)][3:0]};
    assign switchInputType[1] = {2'h0, state_reg.words[wordIndex(`OFS_SWITCH_IN_TYPE_M31)][3:0]};
    assign switchInputType[2] = state_reg.words[wordIndex(`OFS_SWITCH_IN_TYPE_M12A)][5:0];
    assign switchInputType[3] = {2'h0, state_reg.words[wordIndex(`OFS_SWITCH_IN_TYPE_M12B)][3:0]};
    assign switchInputType[4] = {2'h0, state_reg.words[wordIndex(`OFS_SWITCH_IN_TYPE_M32)][3:0]};

    // Pulse constants scaling the counter inputs
    assign switchInputPulseConst[0] = state_reg.words[wordIndex(`OFS_PULSE_CONST_M21)];
    assign switchInputPulseConst[1] = state_reg.words[wordIndex(`OFS_PULSE_CONST_M31)];
    assign switchInputPulseConst[2] = state_reg.words[wordIndex(`OFS_PULSE_CONST_M12A)];
    assign switchInputPulseConst[3] = state_reg.words[wordIndex(`OFS_PULSE_CONST_M12B)];
    assign switchInputPulseConst[4] = state_reg.words[wordIndex(`OFS_PULSE_CONST_M32)];

    // Relay pairs: work mode, drive mode, pulse width
    assign relayWorkMode[0] = state_reg.words[wordIndex(`OFS_RELAY34_WORK_MODE)][0];
    assign relayWorkMode[1] = state_reg.words[wordIndex(`OFS_RELAY56_WORK_MODE)][0];
    assign relayWorkMode[2] = state_reg.words[wordIndex(`OFS_RELAY78_WORK_MODE)][0];
    assign relayDriveMode[0] = state_reg.words[wordIndex(`OFS_RELAY34_DRIVE_MODE)][0];
    assign relayDriveMode[1] = state_reg.words[wordIndex(`OFS_RELAY56_DRIVE_MODE)][0];
    assign relayDriveMode[2] = state_reg.words[wordIndex(`OFS_RELAY78_DRIVE_MODE)][0];
    assign relayPulseWidth[0] = state_reg.words[wordIndex(`OFS_RELAY34_PULSE_WIDTH)];
    assign relayPulseWidth[1] = state_reg.words[wordIndex(`OFS_RELAY56_PULSE_WIDTH)];
    assign relayPulseWidth[2] = state_reg.words[wordIndex(`OFS_RELAY78_PULSE_WIDTH)];

    // Switched outputs: mode, width, energy source
    assign switchedOutMode[0] = state_reg.words[wordIndex(`OFS_OUT_MODE_M21)][0];
    assign switchedOutMode[1] = state_reg.words[wordIndex(`OFS_OUT34_MODE)][0];
    assign switchedOutPulseWidth[0] = state_reg.words[wordIndex(`OFS_OUT_PULSE_WIDTH_M21)];
    assign switchedOutPulseWidth[1] = state_reg.words[wordIndex(`OFS_OUT34_PULSE_WIDTH)];
    assign switchedOutSource[0] = state_reg.words[wordIndex(`OFS_OUT1_SOURCE)][2:0];
    assign switchedOutSource[1] = state_reg.words[wordIndex(`OFS_OUT2_SOURCE)][2:0];
    assign switchedOutSource[2] = state_reg.words[wordIndex(`OFS_OUT3_SOURCE)][2:0];
    assign switchedOutSource[3] = state_reg.words[wordIndex(`OFS_OUT4_SOURCE)][2:0];

    // Analog loop signal types and follow selectors
    assign loopOutputType[0] = state_reg.words[wordIndex(`OFS_LOOP_OUT12_TYPE)][1:0];
    assign loopOutputType[1] = state_reg.words[wordIndex(`OFS_LOOP_OUT34_TYPE)][1:0];
    assign loopSenseInputType[0] = state_reg.words[wordIndex(`OFS_LOOP_IN12_TYPE)][1:0];
    assign loopSenseInputType[1] = state_reg.words[wordIndex(`OFS_LOOP_IN34_TYPE)][1:0];
    assign loopOutputFollow[0] = state_reg.words[wordIndex(`OFS_LOOP_OUT1_FOLLOW_SEL)][4:0];
    assign loopOutputFollow[1] = state_reg.words[wordIndex(`OFS_LOOP_OUT2_FOLLOW_SEL)][4:0];
    assign loopOutputFollow[2] = state_reg.words[wordIndex(`OFS_LOOP_OUT3_FOLLOW_SEL)][4:0];
    assign loopOutputFollow[3] = state_reg.words[wordIndex(`OFS_LOOP_OUT4_FOLLOW_SEL)][4:0];

endmodule : io_expansion_config_regs

// *** dv/io_cfg_checker_sva.sv ***
`include "io_expansion_config_defines.svh"

module io_cfg_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [15:0] regWriteData,
    input wire logic regWriteDone,
    input wire logic regWriteRejected,
    input wire logic [3:0] moduleInstalledSync,
    input wire logic [4:0][5:0] switchInputType,
    input wire logic [2:0][15:0] relayPulseWidth,
    input wire logic [1:0][15:0] switchedOutPulseWidth,
    input wire logic [3:0][4:0] loopOutputFollow
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Write taken at one word address
    sequence s_wr(logic [15:0] a);
        regWrite && !regRead && regAddr == a;
    endsequence

    chk_write_answer:
    assert property (regWrite && !regRead |=> regWriteDone ^ regWriteRejected)
        else $error("write answer missing or doubled");
    chk_const_zero:
    assert property (s_wr(`OFS_PULSE_CONST_M21) ##0 regWriteData == 16'h0000 |=> regWriteRejected)
        else $error("zero pulse constant accepted");
    chk_width_range:
    assert property (s_wr(`OFS_RELAY34_PULSE_WIDTH) ##0
        (regWriteData < 16'h0032 || regWriteData > 16'h0BB8)
        |=> regWriteRejected && $stable(relayPulseWidth[0]))
        else $error("relay width out of range not refused");
    chk_absent_slot:
    assert property (s_wr(`OFS_RELAY56_PULSE_WIDTH) ##0 !moduleInstalledSync[2] |=> regWriteRejected)
        else $error("write to absent module accepted");
    chk_six_land:
    assert property (s_wr(`OFS_SWITCH_IN_TYPE_M12A) |=> regWriteDone |->
        switchInputType[2] == $past(regWriteData[5:0]))
        else $error("six-input type word not applied");
    chk_four_land:
    assert property (s_wr(`OFS_SWITCH_IN_TYPE_M21) |=> regWriteDone |->
        switchInputType[0] == {2'b00, $past(regWriteData[3:0])})
        else $error("four-input type word not applied");
    chk_follow_max:
    assert property (loopOutputFollow[0] <= 5'd29 && loopOutputFollow[1] <= 5'd29 &&
        loopOutputFollow[2] <= 5'd29 && loopOutputFollow[3] <= 5'd29)
        else $error("follow selector above 29");
    chk_reset_width:
    assert property ($rose(rst_n) |-> relayPulseWidth[0] == 16'h0032 &&
        switchedOutPulseWidth[0] == 16'h0014)
        else $error("pulse width reset value wrong");
endmodule : io_cfg_checker

bind io_expansion_config_regs io_cfg_checker chk (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWriteData(regWriteData), .regWriteDone(regWriteDone),
    .regWriteRejected(regWriteRejected), .moduleInstalledSync(moduleInstalledSync),
    .switchInputType(switchInputType), .relayPulseWidth(relayPulseWidth),
    .switchedOutPulseWidth(switchedOutPulseWidth), .loopOutputFollow(loopOutputFollow)
);

// *** dv/host_word_model.sv ***
module host_word_model (
    input wire logic clock,
    output logic [15:0] regAddr,
    output logic regRead,
    output logic regWrite,
    output logic [15:0] regWriteData,
    input wire logic [15:0] regReadData,
    input wire logic regReadValid,
    input wire logic regReadError,
    input wire logic regWriteDone,
    input wire logic regWriteRejected
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        regAddr = 16'h0000;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWriteData = 16'h0000;
    end

    // One word per access; the answer is sampled 1 ns after the following clock edge
    task automatic access(input logic rd, input logic wr, input logic [15:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic [3:0] f);
        @(posedge clock);
        regRead <= rd;
        regWrite <= wr;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clock);
        regRead <= 1'b0;
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWriteData <= ~d;
        #1;
        q = regReadData;
        f = {regReadValid, regReadError, regWriteDone, regWriteRejected};
    endtask : access
endmodule : host_word_model

// *** dv/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] modIn = 4'hF;
    logic [3:0] strap = 4'h5;
    logic [15:0] regAddr, regWriteData, regReadData, q;
    logic regRead, regWrite, regReadValid, regReadError, regWriteDone, regWriteRejected;
    logic [3:0] f, instSync;
    logic [4:0][5:0] swType;
    logic [2:0][15:0] relWidth;
    logic [3:0][4:0] follow;
    logic [3:0][2:0] src;
    logic [1:0][1:0] lt;
    logic [15:0] shadow [0:34];
    int errCount = 0;
    int nChecks = 0;

    io_expansion_config_regs uut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
        .regReadData(regReadData), .regReadValid(regReadValid), .regReadError(regReadError),
        .regWriteDone(regWriteDone), .regWriteRejected(regWriteRejected),
        .moduleInstalled(modIn), .loopVoltageStrap(strap), .switchInputType(swType),
        .switchInputPulseConst(), .relayWorkMode(), .relayDriveMode(),
        .relayPulseWidth(relWidth), .switchedOutMode(), .switchedOutPulseWidth(),
        .switchedOutSource(src), .loopOutputType(lt), .loopSenseInputType(),
        .loopOutputFollow(follow), .moduleInstalledSync(instSync));
    host_word_model host (.clock(clock), .regAddr(regAddr), .regRead(regRead),
        .regWrite(regWrite), .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .regReadError(regReadError),
        .regWriteDone(regWriteDone), .regWriteRejected(regWriteRejected));

    // Legal range of each word by its kind
    function automatic logic legal(logic [15:0] a, logic [15:0] d);
        case (a)
            16'h10A3, 16'h10AA, 16'h10B5, 16'h10BC: return d <= 16'h000F;
            16'h10B0: return d <= 16'h003F;
            16'h10A4, 16'h10AB, 16'h10B1, 16'h10B6, 16'h10BD: return d != 16'h0000;
            16'h10AE, 16'h10B4, 16'h10C0: return d >= 16'h0032 && d <= 16'h0BB8;
            16'h10A6, 16'h10B8: return d >= 16'h0014 && d <= 16'h03E8;
            16'h10A7, 16'h10A8, 16'h10B9, 16'h10BA: return d <= 16'h0004;
            16'h10A9, 16'h10AF, 16'h10BB, 16'h10C1: return d <= 16'h0003;
            16'h10C2, 16'h10C3, 16'h10C4, 16'h10C5: return d <= 16'h001D;
            default: return d <= 16'h0001;
        endcase
    endfunction : legal

    // Owning module slot of a word
    function automatic int slot(logic [15:0] a);
        if (a >= 16'h10C4) return 2;
        if (a >= 16'h10C2) return 0;
        if (a >= 16'h10BC) return 3;
        if (a >= 16'h10B0) return 2;
        if (a >= 16'h10AA) return 1;
        return 0;
    endfunction : slot

    // Word value after reset, straps 0101
    function automatic logic [15:0] rv(logic [15:0] a);
        case (a)
            16'h10A6, 16'h10B8: return 16'h0014;
            16'h10AE, 16'h10B4, 16'h10C0: return 16'h0032;
            16'h10A9, 16'h10BB: return 16'h0002;
            16'h10AF, 16'h10C1: return 16'h0001;
            default: return 16'h0000;
        endcase
    endfunction : rv

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Write, judge the answer, read back
    task automatic wchk(logic [15:0] a, logic [15:0] d);
        logic ok;
        ok = legal(a, d) && modIn[slot(a)];
        host.access(1'b0, 1'b1, a, d, q, f);
        chk({12'h000, f}, ok ? 16'h0002 : 16'h0001);
        if (ok)
            shadow[int'(a - 16'h10A3)] = d;
        host.access(1'b1, 1'b0, a, 16'h0000, q, f);
        chk(q, shadow[int'(a - 16'h10A3)]);
    endtask : wchk

    task automatic t_reset();
        host.access(1'b0, 1'b1, 16'h10A4, 16'h0005, q, f);
        chk({12'h000, f}, 16'h0001);
        for (int a = 16'h10A3; a <= 16'h10C5; a++)
        begin
            shadow[a - 16'h10A3] = rv(16'(a));
            host.access(1'b1, 1'b0, 16'(a), 16'h0000, q, f);
            chk(q, shadow[a - 16'h10A3]);
        end
        host.access(1'b1, 1'b0, 16'h10C6, 16'h0000, q, f);
        chk({12'h000, f}, 16'h0004);
        chk({14'h0000, lt[0]}, shadow[6]);
        $display("test reset done");
    endtask : t_reset

    task automatic t_sweep(logic [3:0] inst);
        logic [15:0] vals [0:20] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
            16'h0005, 16'h000F, 16'h0010, 16'h0013, 16'h0014, 16'h001D, 16'h001E,
            16'h0031, 16'h0032, 16'h03E8, 16'h03E9, 16'h0BB8, 16'h0BB9, 16'h003F,
            16'h0040, 16'hFFFF};
        @(posedge clock);
        modIn <= inst;
        repeat (4) @(posedge clock);
        for (int a = 16'h10A3; a <= 16'h10C5; a++)
            foreach (vals[i])
                wchk(16'(a), vals[i]);
        chk({12'h000, instSync}, {12'h000, inst});
        host.access(1'b0, 1'b1, 16'h10A2, 16'h0001, q, f);
        chk({12'h000, f}, 16'h0001);
        $display("test sweep done");
    endtask : t_sweep

    task automatic t_ports();
        for (int v = 0; v <= 30; v++)
        begin
            wchk(16'h10C2, 16'(v));
            chk({11'h000, follow[0]}, shadow[31]);
        end
        chk(relWidth[0], shadow[11]);
        chk({10'h000, swType[2]}, shadow[13]);
        host.access(1'b1, 1'b1, 16'h10A7, 16'h0003, q, f);
        chk({12'h000, f}, 16'h0008);
        wchk(16'h10A7, 16'h0004);
        chk({13'h0000, src[0]}, shadow[4]);
        $display("test ports done");
    endtask : t_ports

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Clock and main sequence
    always #5 clock = ~clock;
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_sweep(4'hB);
        t_sweep(4'hF);
        t_ports();
        wrap_up();
    end

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge clock);
        errCount++;
        wrap_up();
    end
endmodule : tb_top
